// [rtl/fsp_pkg.sv]
// Constants, types and state layout of the flash self-programming sequencer.
package fsp_pkg;

	// Register port and control register layout.
	localparam int ADDR_W = 3;
	localparam logic [2:0] CTRL_OFS = 3'h0;
	localparam int BIT_INT_EN = 7;
	localparam int BIT_BUSY = 6;
	localparam int BIT_REEN = 4;
	localparam int BIT_LOCKSET = 3;
	localparam int BIT_PGWR = 2;
	localparam int BIT_PGER = 1;
	localparam int BIT_EN = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Legal command patterns in the low five control bits.
	localparam logic [4:0] PAT_REEN = 5'h11;
	localparam logic [4:0] PAT_LOCKSET = 5'h09;
	localparam logic [4:0] PAT_WRITE = 5'h05;
	localparam logic [4:0] PAT_ERASE = 5'h03;
	localparam logic [4:0] PAT_LOAD = 5'h01;

	// Pointer fields and special pointer values.
	localparam int PAGE_LSB = 7;
	localparam int PAGE_W = 7;
	localparam int WORD_LSB = 1;
	localparam int WORD_W = 6;
	localparam int PAGE_WORDS = 64;
	localparam logic [6:0] HALT_FIRST_PAGE = 7'h70;
	localparam logic [15:0] Z_FUSE_LO = 16'h0000;
	localparam logic [15:0] Z_LOCK = 16'h0001;
	localparam logic [15:0] Z_FUSE_HI = 16'h0003;

	// Lock byte layout.
	localparam logic [7:0] LOCK_RESET = 8'hff;
	localparam logic [1:0] LOCK_UNUSED = 2'h3;
	localparam int LOCK_BOOT_LSB = 2;
	localparam int LOCK_BOOT_W = 4;
	localparam logic [15:0] ERASED_WORD = 16'hffff;

	// Arming windows and programming time.
	localparam logic [2:0] ARM_SPM_CYCLES = 3'h4;
	localparam logic [2:0] ARM_LPM_CYCLES = 3'h3;
	localparam int CLK_PERIOD_NS = 40;
	localparam int PROG_MIN_NS = 3700000;
	localparam int PROG_MAX_NS = 4500000;
	localparam int PROG_MIN_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;
	localparam int PROG_CNT_W = 24;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROG} fsp_state_type;
	typedef enum logic [2:0] {CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN} fsp_cmd_type;

	// Operands that travel with a store or load program instruction.
	typedef struct packed {
		logic [15:0] zPtr;
		logic [7:0] dataLow;
		logic [7:0] dataHigh;
	} fsp_instr_type;

	typedef struct packed {
		fsp_state_type st;
		fsp_cmd_type cmd;
		logic [2:0] age;
		logic [PROG_CNT_W-1:0] progCnt;
		logic [PAGE_W-1:0] progPage;
		logic intEn;
		logic busy;
		logic halt;
		logic [7:0] lockByte;
		logic [7:0] lockData;
		logic [PAGE_WORDS-1:0] bufValid;
		logic [7:0] rdData;
		logic lpmValid;
		logic [7:0] lpmData;
		logic [15:0] bufRd;
	} fsp_regs_type;

endpackage : fsp_pkg

// [rtl/fsp_seq.sv]
// Flash self-programming sequencer: command arming, page buffer, erase, write and lock bits.
//
// Requirements
// RQ1: Erase pattern plus store within four cycles erases the pointer's page.
// RQ2: Erasing a halting-section page stalls the CPU; other pages leave it running.
// RQ3: Load pattern plus store writes the data word to the buffer slot.
// RQ4: Buffer clears after page write, re-enable bit write, and system reset.
// RQ5: Software loads each buffer slot at most once between buffer clears.
// RQ6: An EEPROM write during page loading discards all loaded buffer words.
// RQ7: Write pattern plus store within four cycles programs the buffer into the page.
// RQ8: Writing a halting-section page stalls the CPU until it completes.
// RQ9: With interrupt enabled, request stays high while the enable bit reads zero.
// RQ10: During erase or write the concurrent-read section is blocked and busy flag set.
// RQ11: Software re-enables the section before reading it after programming.
// RQ12: Lock-set pattern plus store programs boot lock bits from the low data byte.
// RQ13: Each zero among low data bits five to two programs that boot lock bit.
// RQ14: Lock-bit programming blocks no section and never stalls the CPU.
// RQ15: Software should use pointer one and ones in bits seven, six, one, zero.
// RQ16: An EEPROM write blocks all programming commands and fuse or lock readback.
// RQ17: Armed lock-set plus load within three cycles with pointer one returns lock bits.
// RQ18: Arming expires after readback, three cycles without load, or four without store; the code keeps a lock-set armed four cycles, refusing loads after three.
// RQ19: Lock byte holds boot locks in bits five to two, memory locks in one and zero.
// RQ20: Pointer zero returns fuse low byte, pointer three the fuse high byte.
// RQ21: Readback shows programmed bits as zero and unprogrammed bits as one.
// RQ22: Erase, write and lock programming each last between 3.7 and 4.5 ms.
// RQ23: Control writes with an illegal low five-bit pattern are ignored; the code still takes the interrupt enable bit from them.
// RQ24: Starting a page load also clears the section busy flag.
`timescale 1ns/1ns
module fsp_seq #(
	parameter int PROG_CYCLES = fsp_pkg::PROG_MIN_CYCLES,
	parameter logic [7:0] LOCK_INIT = fsp_pkg::LOCK_RESET
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register port.
	input wire logic [fsp_pkg::ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRData,
	// Instructions from the CPU core.
	input wire logic spmExec,
	input wire logic lpmExec,
	input wire fsp_pkg::fsp_instr_type instr,
	output logic lpmValid,
	output logic [7:0] lpmData,
	// Neighbouring blocks.
	input wire logic eeWriteActive,
	input wire logic [7:0] fuseLow,
	input wire logic [7:0] fuseHigh,
	// Flash array control.
	output logic progActive,
	output logic progErase,
	output logic progWrite,
	output logic progLock,
	output logic [fsp_pkg::PAGE_W-1:0] progPage,
	input wire logic [fsp_pkg::WORD_W-1:0] bufRdAddr,
	output logic [15:0] bufRdData,
	// CPU side status.
	output logic cpuStall,
	output logic sectionBlocked,
	output logic readyIrq
);

	fsp_pkg::fsp_regs_type r_q;
	fsp_pkg::fsp_regs_type r_d;
	logic [15:0] pageBuf [fsp_pkg::PAGE_WORDS];
	logic bufWe;
	logic [fsp_pkg::WORD_W-1:0] bufIdx;
	logic ctrlWr;
	logic inWindow;
	logic spmTake;
	logic lpmTake;
	logic progDone;
	logic [fsp_pkg::PAGE_W-1:0] zPage;

	function automatic logic isLegal(input logic [4:0] pat);
		return pat inside {fsp_pkg::PAT_REEN, fsp_pkg::PAT_LOCKSET, fsp_pkg::PAT_WRITE,
			fsp_pkg::PAT_ERASE, fsp_pkg::PAT_LOAD};
	endfunction : isLegal

	function automatic fsp_pkg::fsp_cmd_type decodeCmd(input logic [4:0] pat);
		unique case (pat)
			fsp_pkg::PAT_REEN: return fsp_pkg::CMD_REEN;
			fsp_pkg::PAT_LOCKSET: return fsp_pkg::CMD_LOCK;
			fsp_pkg::PAT_WRITE: return fsp_pkg::CMD_WRITE;
			fsp_pkg::PAT_ERASE: return fsp_pkg::CMD_ERASE;
			default: return fsp_pkg::CMD_LOAD;
		endcase
	endfunction : decodeCmd

	// Control register image; command bits show only while a command is pending or running.
	function automatic logic [7:0] ctrlImage(input fsp_pkg::fsp_regs_type s);
		logic [7:0] v;
		v = fsp_pkg::CTRL_RESET;
		v[fsp_pkg::BIT_INT_EN] = s.intEn;
		v[fsp_pkg::BIT_BUSY] = s.busy;
		if (s.st != fsp_pkg::ST_IDLE) begin
			v[fsp_pkg::BIT_EN] = 1'b1;
			v[fsp_pkg::BIT_REEN] = (s.cmd == fsp_pkg::CMD_REEN);
			v[fsp_pkg::BIT_LOCKSET] = (s.cmd == fsp_pkg::CMD_LOCK);
			v[fsp_pkg::BIT_PGWR] = (s.cmd == fsp_pkg::CMD_WRITE);
			v[fsp_pkg::BIT_PGER] = (s.cmd == fsp_pkg::CMD_ERASE);
		end
		return v;
	endfunction : ctrlImage

	assign ctrlWr = regWr && (regAddr == fsp_pkg::CTRL_OFS);
	assign inWindow = (r_q.st == fsp_pkg::ST_ARMED) && (r_q.age < fsp_pkg::ARM_SPM_CYCLES);
	assign spmTake = inWindow && spmExec && !eeWriteActive; // see RQ16
	assign lpmTake = inWindow && lpmExec && !spmExec && !eeWriteActive
		&& (r_q.cmd == fsp_pkg::CMD_LOCK) && (r_q.age < fsp_pkg::ARM_LPM_CYCLES); // see RQ17
	assign progDone = (r_q.st == fsp_pkg::ST_PROG)
		&& (r_q.progCnt == fsp_pkg::PROG_CNT_W'(PROG_CYCLES - 1)); // see RQ22
	assign zPage = instr.zPtr[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_W];
	assign bufIdx = instr.zPtr[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_W];
	assign bufWe = spmTake && (r_q.cmd == fsp_pkg::CMD_LOAD);

	always_comb begin
		r_d = r_q;
		r_d.lpmValid = 1'b0;
		r_d.rdData = 8'h00;
		if (regRd && (regAddr == fsp_pkg::CTRL_OFS)) begin
			r_d.rdData = ctrlImage(r_q);
		end
		if (ctrlWr) begin
			r_d.intEn = regWData[fsp_pkg::BIT_INT_EN];
		end
		r_d.bufRd = r_q.bufValid[bufRdAddr] ? pageBuf[bufRdAddr] : fsp_pkg::ERASED_WORD;
		unique case (r_q.st)
			fsp_pkg::ST_IDLE, fsp_pkg::ST_ARMED: begin
				if (r_q.st == fsp_pkg::ST_ARMED) begin
					r_d.age = r_q.age + 3'h1;
					if (r_q.age == fsp_pkg::ARM_SPM_CYCLES - 3'h1) begin
						r_d.st = fsp_pkg::ST_IDLE; // see RQ18
					end
				end
				if (spmTake) begin
					r_d.st = fsp_pkg::ST_IDLE;
					unique case (r_q.cmd)
						fsp_pkg::CMD_LOAD: begin
							r_d.bufValid[bufIdx] = 1'b1; // see RQ3
							r_d.busy = 1'b0; // see RQ24
						end
						fsp_pkg::CMD_ERASE, fsp_pkg::CMD_WRITE: begin
							r_d.st = fsp_pkg::ST_PROG; // see RQ1, RQ7
							r_d.progPage = zPage;
							r_d.progCnt = '0;
							r_d.busy = 1'b1; // see RQ10
							r_d.halt = (zPage >= fsp_pkg::HALT_FIRST_PAGE); // see RQ2, RQ8
						end
						fsp_pkg::CMD_LOCK: begin
							r_d.st = fsp_pkg::ST_PROG; // see RQ12
							r_d.lockData = instr.dataLow;
							r_d.progCnt = '0;
							r_d.halt = 1'b0; // see RQ14
						end
						fsp_pkg::CMD_REEN: begin
							r_d.busy = 1'b0;
						end
					endcase
				end else if (lpmTake) begin
					r_d.st = fsp_pkg::ST_IDLE; // see RQ18
					r_d.lpmValid = 1'b1;
					unique case (instr.zPtr)
						fsp_pkg::Z_FUSE_LO: r_d.lpmData = fuseLow; // see RQ20, RQ21
						fsp_pkg::Z_FUSE_HI: r_d.lpmData = fuseHigh;
						default: r_d.lpmData = {fsp_pkg::LOCK_UNUSED, r_q.lockByte[5:0]}; // see RQ19
					endcase
				end
				if (ctrlWr && !eeWriteActive && isLegal(regWData[4:0])) begin // see RQ23, RQ16
					r_d.st = fsp_pkg::ST_ARMED;
					r_d.cmd = decodeCmd(regWData[4:0]);
					r_d.age = 3'h0;
					if (decodeCmd(regWData[4:0]) == fsp_pkg::CMD_REEN) begin
						// A load taken in this same cycle keeps its word, so the set wins.
						r_d.bufValid = '0; // see RQ4
						if (bufWe) begin
							r_d.bufValid[bufIdx] = 1'b1;
						end
					end
				end
				if (eeWriteActive) begin
					r_d.bufValid = '0; // see RQ6
				end
			end
			fsp_pkg::ST_PROG: begin
				// Arming is refused while the array is busy; only the interrupt enable is taken.
				r_d.progCnt = r_q.progCnt + fsp_pkg::PROG_CNT_W'(1);
				if (progDone) begin
					r_d.st = fsp_pkg::ST_IDLE;
					r_d.halt = 1'b0;
					if (r_q.cmd == fsp_pkg::CMD_WRITE) begin
						r_d.bufValid = '0; // see RQ4
					end
					if (r_q.cmd == fsp_pkg::CMD_LOCK) begin
						r_d.lockByte[fsp_pkg::LOCK_BOOT_LSB +: fsp_pkg::LOCK_BOOT_W] =
							r_q.lockByte[fsp_pkg::LOCK_BOOT_LSB +: fsp_pkg::LOCK_BOOT_W]
							& r_q.lockData[fsp_pkg::LOCK_BOOT_LSB +: fsp_pkg::LOCK_BOOT_W]; // see RQ13
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r_q <= '{st: fsp_pkg::ST_IDLE, cmd: fsp_pkg::CMD_LOAD, age: 3'h0, progCnt: '0,
				progPage: '0, intEn: 1'b0, busy: 1'b0, halt: 1'b0, lockByte: LOCK_INIT,
				lockData: 8'hff, bufValid: '0, rdData: 8'h00, lpmValid: 1'b0,
				lpmData: 8'h00, bufRd: fsp_pkg::ERASED_WORD}; // see RQ4
		end else begin
			r_q <= r_d;
		end
	end

	// The buffer words carry no reset; the valid bits decide what the array sees.
	always_ff @(posedge clk) begin
		if (bufWe) begin
			pageBuf[bufIdx] <= {instr.dataHigh, instr.dataLow};
		end
	end

	assign regRData = r_q.rdData;
	assign lpmValid = r_q.lpmValid;
	assign lpmData = r_q.lpmData;
	assign bufRdData = r_q.bufRd;
	assign progActive = (r_q.st == fsp_pkg::ST_PROG);
	assign progErase = progActive && (r_q.cmd == fsp_pkg::CMD_ERASE);
	assign progWrite = progActive && (r_q.cmd == fsp_pkg::CMD_WRITE);
	assign progLock = progActive && (r_q.cmd == fsp_pkg::CMD_LOCK);
	assign progPage = r_q.progPage;
	assign cpuStall = r_q.halt;
	assign sectionBlocked = r_q.busy;
	assign readyIrq = r_q.intEn && (r_q.st == fsp_pkg::ST_IDLE); // see RQ9

	// Checks.
	logic [fsp_pkg::PROG_CNT_W-1:0] progLen;
	logic [3:0] bootLocks;
	assign bootLocks = r_q.lockByte[fsp_pkg::LOCK_BOOT_LSB +: fsp_pkg::LOCK_BOOT_W];
	logic [7:0] ctrlNow;
	assign ctrlNow = ctrlImage(r_q);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			progLen <= '0;
		end else if (progActive) begin
			progLen <= progLen + fsp_pkg::PROG_CNT_W'(1);
		end else begin
			progLen <= '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_erase_start;
		spmTake && (r_q.cmd == fsp_pkg::CMD_ERASE) |=> progErase && sectionBlocked
			&& (progPage == $past(zPage));
	endproperty
	a_erase_start: assert property (p_erase_start) else $error("Erase did not start."); // see RQ1

	property p_halt_section;
		progActive && !progLock |-> cpuStall == (progPage >= fsp_pkg::HALT_FIRST_PAGE);
	endproperty
	a_halt_section: assert property (p_halt_section) else $error("Stall wrong."); // see RQ2, RQ8

	property p_load_word;
		bufWe |=> r_q.bufValid[$past(bufIdx)] && !sectionBlocked;
	endproperty
	a_load_word: assert property (p_load_word) else $error("Word not loaded."); // see RQ3, RQ24

	property p_write_clears;
		$fell(progActive) && (r_q.cmd == fsp_pkg::CMD_WRITE) |-> r_q.bufValid == '0;
	endproperty
	a_write_clears: assert property (p_write_clears) else $error("Buffer kept."); // see RQ4

	property p_ee_discard;
		eeWriteActive && !progActive |=> (r_q.bufValid == '0) && !progActive && !lpmValid;
	endproperty
	a_ee_discard: assert property (p_ee_discard) else $error("EEPROM interlock."); // see RQ6, RQ16

	property p_irq_level;
		r_q.intEn |-> readyIrq == !ctrlNow[fsp_pkg::BIT_EN];
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong."); // see RQ9

	property p_busy_hold;
		(progErase || progWrite) |-> sectionBlocked;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("Section not blocked."); // see RQ10

	property p_lock_program;
		$fell(progActive) && (r_q.cmd == fsp_pkg::CMD_LOCK) |->
			bootLocks == ($past(bootLocks) & r_q.lockData[5:2]);
	endproperty
	a_lock_program: assert property (p_lock_program) else $error("Lock bits wrong."); // see RQ13

	property p_lock_free;
		progLock |-> !cpuStall;
	endproperty
	a_lock_free: assert property (p_lock_free) else $error("Lock stalls CPU."); // see RQ14

	property p_lock_read;
		lpmTake && (instr.zPtr == fsp_pkg::Z_LOCK) |=> lpmValid
			&& (lpmData == {fsp_pkg::LOCK_UNUSED, r_q.lockByte[5:0]}) && !progActive;
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("Lock readback."); // see RQ17, RQ19

	property p_fuse_read;
		lpmTake && (instr.zPtr == fsp_pkg::Z_FUSE_HI) |=> lpmValid && (lpmData == $past(fuseHigh));
	endproperty
	a_fuse_read: assert property (p_fuse_read) else $error("Fuse readback."); // see RQ20, RQ21

	property p_expire;
		((r_q.st == fsp_pkg::ST_ARMED) && !spmExec && !lpmExec && !regWr)
			[*4] |=> (r_q.st == fsp_pkg::ST_IDLE);
	endproperty
	a_expire: assert property (p_expire) else $error("Arming did not expire."); // see RQ18

	property p_duration;
		$fell(progActive) |-> $past(progLen) == fsp_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
	endproperty
	a_duration: assert property (p_duration) else $error("Programming time."); // see RQ22

	property p_illegal;
		ctrlWr && !isLegal(regWData[4:0]) && (r_q.st == fsp_pkg::ST_IDLE) |=>
			(r_q.st == fsp_pkg::ST_IDLE);
	endproperty
	a_illegal: assert property (p_illegal) else $error("Illegal pattern armed."); // see RQ23

	property p_reenable;
		spmTake && (r_q.cmd == fsp_pkg::CMD_REEN) |=> !sectionBlocked;
	endproperty
	a_reenable: assert property (p_reenable) else $error("Section not re-enabled."); // see RQ11

	c_erase_done: cover property ($fell(progErase));
	c_page_write: cover property ($fell(progWrite));
	c_lock_done: cover property ($fell(progLock));
	c_readback: cover property (lpmValid);
	c_reenable: cover property (spmTake && (r_q.cmd == fsp_pkg::CMD_REEN));

endmodule : fsp_seq

// [tb/fsp_cpu_model.sv]
// CPU core model that issues store and load program instructions after an arming write.
`timescale 1ns/1ns
module fsp_cpu_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Requests from the bench.
	input wire logic reqGo,
	input wire logic reqLpm,
	input wire logic [2:0] reqDelay,
	input wire fsp_pkg::fsp_instr_type reqInstr,
	// Instruction strobes toward the sequencer.
	output logic spmExec,
	output logic lpmExec,
	output fsp_pkg::fsp_instr_type instr
);
	logic pend;
	logic isLpm;
	logic [2:0] cnt;
	fsp_pkg::fsp_instr_type held;
	logic curLpm;
	logic [2:0] curCnt;
	fsp_pkg::fsp_instr_type curInstr;

	// A request may fire in the cycle it arrives, so a fresh request is looked at first.
	assign curLpm = reqGo ? reqLpm : isLpm;
	assign curCnt = reqGo ? reqDelay : cnt;
	assign curInstr = reqGo ? reqInstr : held;

	// Outside an instruction the operands toggle every cycle, so stale values are never trusted.
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend <= 1'b0;
			isLpm <= 1'b0;
			cnt <= 3'h0;
			held <= '0;
			spmExec <= 1'b0;
			lpmExec <= 1'b0;
			instr <= '0;
		end else begin
			isLpm <= curLpm;
			held <= curInstr;
			if ((reqGo || pend) && curCnt == 3'h0) begin
				spmExec <= !curLpm;
				lpmExec <= curLpm;
				instr <= curInstr;
				pend <= 1'b0;
			end else begin
				spmExec <= 1'b0;
				lpmExec <= 1'b0;
				instr <= ~instr;
				pend <= reqGo || pend;
				if (reqGo || pend) cnt <= curCnt - 3'h1;
			end
		end
	end
endmodule : fsp_cpu_model

// [tb/tb_fsp_seq.sv]
// Self-checking bench for the flash self-programming sequencer.
`timescale 1ns/1ns
module tb_fsp_seq;
	localparam int PROG_N = 20;
	logic clk, rst_b, regWr, regRd, spmExec, lpmExec, lpmValid, eeWriteActive;
	logic [fsp_pkg::ADDR_W-1:0] regAddr;
	logic [7:0] regWData, regRData, lpmData, fuseLow, fuseHigh, lk;
	fsp_pkg::fsp_instr_type instr, reqInstr;
	logic progActive, progErase, progWrite, progLock, cpuStall, sectionBlocked, readyIrq;
	logic [fsp_pkg::PAGE_W-1:0] progPage;
	logic [fsp_pkg::WORD_W-1:0] bufRdAddr;
	logic [15:0] bufRdData, d;
	logic reqGo, reqLpm, rdPrev;
	logic [2:0] reqDelay;
	logic [15:0] expQ[$];
	int errTotal = 0;
	int checkCount = 0;
	int seed = 3;
	logic [7:0] bad[4] = '{8'h07, 8'h1f, 8'h0b, 8'h15};
	logic [15:0] rbPtr[3] = '{16'h0000, 16'h0003, 16'h0001};

	fsp_seq #(.PROG_CYCLES(PROG_N)) uut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
		.regWData(regWData), .regWr(regWr), .regRd(regRd), .regRData(regRData),
		.spmExec(spmExec), .lpmExec(lpmExec), .instr(instr), .lpmValid(lpmValid),
		.lpmData(lpmData), .eeWriteActive(eeWriteActive), .fuseLow(fuseLow),
		.fuseHigh(fuseHigh), .progActive(progActive), .progErase(progErase),
		.progWrite(progWrite), .progLock(progLock), .progPage(progPage),
		.bufRdAddr(bufRdAddr), .bufRdData(bufRdData), .cpuStall(cpuStall),
		.sectionBlocked(sectionBlocked), .readyIrq(readyIrq));
	fsp_cpu_model cpu (.clk(clk), .rst_b(rst_b), .reqGo(reqGo), .reqLpm(reqLpm),
		.reqDelay(reqDelay), .reqInstr(reqInstr), .spmExec(spmExec), .lpmExec(lpmExec),
		.instr(instr));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic printVerdict();
		$display("comparisons %0d mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : printVerdict

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Arming write and the instruction request leave together; the model adds the delay.
	task automatic cmd(input logic [7:0] ctl, input logic lpm, input logic [2:0] dly,
		input logic [15:0] z, input logic [15:0] dat);
		@(posedge clk);
		regAddr <= fsp_pkg::CTRL_OFS;
		regWData <= ctl;
		regWr <= 1'b1;
		reqGo <= 1'b1;
		reqLpm <= lpm;
		reqDelay <= dly;
		reqInstr <= {z, dat[7:0], dat[15:8]};
		@(posedge clk);
		regWr <= 1'b0;
		reqGo <= 1'b0;
		repeat (dly) @(posedge clk);
	endtask : cmd

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		expQ.push_back(16'(e));
		@(posedge clk);
		regRd <= 1'b0;
	endtask : rd

	task automatic bufChk(input logic [5:0] w, input logic [15:0] e);
		@(posedge clk);
		bufRdAddr <= w;
		@(posedge clk);
		@(negedge clk);
		check("buffer word", bufRdData, e);
	endtask : bufChk

	task automatic load(input logic [5:0] w, input logic [2:0] dly);
		d = 16'($random(seed));
		cmd(8'h01, 1'b0, dly, {9'h000, w, 1'b0}, d);
		bufChk(w, d);
	endtask : load

	task automatic idleChk();
		repeat (8) begin
			@(negedge clk);
			check("no programming", 16'(progActive), 16'h0);
		end
	endtask : idleChk

	task automatic runProg(input logic [2:0] kind, input logic [6:0] page, input logic [2:0] st,
		input logic irq);
		int n;
		n = 0;
		repeat (8) if (progActive !== 1'b1) @(negedge clk);
		check("kind", 16'({progErase, progWrite, progLock}), 16'(kind));
		check("stall", 16'(cpuStall), 16'(st[2]));
		check("busy irq", 16'({sectionBlocked, readyIrq}), 16'(st[1:0]));
		if (!kind[0]) check("page", 16'(progPage), 16'(page));
		while (progActive === 1'b1 && n < 200) begin
			n++;
			@(negedge clk);
		end
		check("duration", n[15:0], PROG_N[15:0]);
		check("ready irq", 16'(readyIrq), 16'(irq));
	endtask : runProg

	always @(posedge clk) rdPrev <= regRd;

	// Every answer on either port takes the oldest expectation off the queue.
	always @(negedge clk) begin
		if (rdPrev === 1'b1 || lpmValid === 1'b1) begin
			if (expQ.size() == 0) begin
				check("unexpected answer", 16'h1, 16'h0);
			end else if (rdPrev === 1'b1) begin
				check("regRData", 16'(regRData), expQ.pop_front());
			end else begin
				check("lpmData", 16'(lpmData), expQ.pop_front());
			end
		end
	end

	initial begin
		#(4000 * 40);
		errTotal++;
		printVerdict();
	end

	initial begin
		rst_b = 1'b0;
		regAddr = '0;
		regWData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		eeWriteActive = 1'b0;
		bufRdAddr = '0;
		reqGo = 1'b0;
		reqLpm = 1'b0;
		reqDelay = 3'h0;
		reqInstr = '0;
		fuseLow = 8'($random(seed));
		fuseHigh = 8'($random(seed));
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		check("buffer after reset", bufRdData, 16'hffff);
		rd(fsp_pkg::CTRL_OFS, fsp_pkg::CTRL_RESET);
		rd(3'h5, 8'h00);
		foreach (bad[i]) begin
			cmd(bad[i], 1'b0, 3'h0, 16'h0280, 16'h1234);
			rd(fsp_pkg::CTRL_OFS, 8'h00);
			idleChk();
		end
		load(6'h00, 3'h0);
		load(6'h3f, 3'h1);
		cmd(8'h83, 1'b0, 3'h3, 16'h0280, 16'($random(seed)));
		runProg(3'b100, 7'h05, 3'b010, 1'b1);
		rd(fsp_pkg::CTRL_OFS, 8'hc0);
		load(6'h05, 3'h2);
		check("busy after load", 16'(sectionBlocked), 16'h0);
		cmd(8'h03, 1'b0, 3'h0, 16'h3800, 16'h0000);
		runProg(3'b100, 7'h70, 3'b110, 1'b0);
		cmd(8'h11, 1'b0, 3'h0, 16'h0000, 16'h0000);
		bufChk(6'h00, 16'hffff);
		check("busy after reenable", 16'(sectionBlocked), 16'h0);
		load(6'h02, 3'h3);
		cmd(8'h05, 1'b0, 3'h1, 16'h3880, 16'($random(seed)));
		runProg(3'b010, 7'h71, 3'b110, 1'b0);
		bufChk(6'h02, 16'hffff);
		cmd(8'h03, 1'b0, 3'h4, 16'h0280, 16'h0000);
		idleChk();
		load(6'h07, 3'h0);
		@(posedge clk);
		eeWriteActive <= 1'b1;
		@(posedge clk);
		eeWriteActive <= 1'b0;
		bufChk(6'h07, 16'hffff);
		@(posedge clk);
		eeWriteActive <= 1'b1;
		cmd(8'h03, 1'b0, 3'h0, 16'h0280, 16'h0000);
		idleChk();
		cmd(8'h09, 1'b1, 3'h0, 16'h0001, 16'h0000);
		rd(fsp_pkg::CTRL_OFS, 8'h00);
		eeWriteActive <= 1'b0;
		load(6'h09, 3'h1);
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		bufChk(6'h09, 16'hffff);
		d = 16'($random(seed)) | 16'h00c3;
		lk = 8'hff;
		lk[5:2] = lk[5:2] & d[5:2];
		cmd(8'h09, 1'b0, 3'h1, 16'h0001, d);
		runProg(3'b001, 7'h00, 3'b000, 1'b0);
		foreach (rbPtr[k]) begin
			expQ.push_back(16'(k == 0 ? fuseLow : k == 1 ? fuseHigh : lk));
			cmd(8'h09, 1'b1, 3'(k), rbPtr[k], 16'h0000);
			repeat (3) @(posedge clk);
		end
		rd(fsp_pkg::CTRL_OFS, 8'h00);
		cmd(8'h09, 1'b1, 3'h3, 16'h0001, 16'h0000);
		repeat (4) @(posedge clk);
		rd(fsp_pkg::CTRL_OFS, 8'h00);
		repeat (4) @(posedge clk);
		check("queue drained", 16'(expQ.size()), 16'h0);
		printVerdict();
	end
endmodule : tb_fsp_seq
